/* File: ipc_pkg.sv */
package ipc_pkg;
	localparam int IPC_NUM_LINES = 4;
	localparam int IPC_NUM_PERIPH = 5;
	localparam int IPC_NUM_SRC = 11;
	localparam logic [7:0] IPC_SENSE_RESET = 8'h00;
	localparam logic [3:0] IPC_ADDR_SENSE = 4'h0;
	localparam logic [3:0] IPC_ADDR_ENABLE = 4'h1;
	localparam logic [3:0] IPC_ADDR_PEND = 4'h2;
	localparam logic [3:0] IPC_ADDR_STATUS = 4'h3;
	localparam logic [4:0] IPC_ENABLE_RESET = 5'h00;
	localparam logic [1:0] IPC_SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] IPC_SENSE_RISE = 2'h1;
	localparam logic [1:0] IPC_SENSE_FALL = 2'h2;
	localparam logic [1:0] IPC_SENSE_BOTH = 2'h3;
	localparam logic [15:0] IPC_VEC_RESET = 16'hFFFE;
	localparam logic [15:0] IPC_VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] IPC_VEC_LINE0 = 16'hFFF8;
	localparam logic [15:0] IPC_VEC_LINE1 = 16'hFFF6;
	localparam logic [15:0] IPC_VEC_LINE2 = 16'hFFF4;
	localparam logic [15:0] IPC_VEC_LINE3 = 16'hFFF2;
	localparam logic [15:0] IPC_VEC_AT_CMP = 16'hFFEA;
	localparam logic [15:0] IPC_VEC_AT_OVF = 16'hFFE8;
	localparam logic [15:0] IPC_VEC_LT_CAP = 16'hFFE6;
	localparam logic [15:0] IPC_VEC_LT_RTB = 16'hFFE4;
	localparam logic [15:0] IPC_VEC_SERIAL = 16'hFFE2;
	// source index order = priority order, index 0 highest
	localparam logic [10:0] IPC_HALT_WAKE_MASK = 11'b110_1011_1101;
	typedef enum logic [1:0] {
		IPC_ST_RUN = 2'b00,
		IPC_ST_SVC = 2'b01,
		IPC_ST_WAIT = 2'b11,
		IPC_ST_HALT = 2'b10
	} ipc_state_e;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ipc_bus_s;
endpackage : ipc_pkg

/* File: ipc_interrupt_priority_controller.sv */
// Functional notes
// - maskable service only when mask clear
// - masked requests stay pending until unmasked
// - reset sets global mask bit
// - service after instruction, stack, mask, vector
// - return instruction clears mask bit
// - fixed priority in vector table order
// - trap serviced regardless of mask
// - line vectors need signal and clear mask
// - timer compare/overflow vectors; overflow wakes halt
// - capture/real-time vectors; real-time wakes halt
// - every source wakes from wait
// - only listed sources end halt
// - edge requests latched, cleared on entry
// - low contributing pin blocks combined request
// - peripheral needs enable and clear mask
// - peripheral cleared by software clear
// - clear sequence discards pending latch
// - one 2-bit sensitivity field per line, four in all
// - sensitivity writes only while mask set
// - sensitivity encoding of each field
`timescale 1ns/10ps
`default_nettype none
module ipc_interrupt_priority_controller (
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic [3:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [7:0] REG_RDATA_OUT,
	input wire logic [3:0] EXT_LINE_IN,
	input wire logic [3:0] EXT_NAND_BLOCK_N_IN,
	input wire logic [4:0] PERIPH_FLAG_SET_IN,
	input wire logic [4:0] PERIPH_FLAG_CLR_IN,
	input wire logic INSTR_END_IN,
	input wire logic TRAP_EXEC_IN,
	input wire logic IRQ_RETURN_INSTR_EXEC_IN,
	input wire logic WAIT_EXEC_IN,
	input wire logic HALT_EXEC_IN,
	input wire logic STACK_DONE_IN,
	output logic GLOBAL_MASK_OUT,
	output logic SVC_REQ_OUT,
	output logic STACK_PUSH_OUT,
	output logic STACK_POP_OUT,
	output logic [15:0] VECTOR_OUT,
	output logic [3:0] SRC_ID_OUT,
	output logic WAIT_STATE_OUT,
	output logic HALT_STATE_OUT,
	output logic WAKE_OUT
);
	ipc_pkg::ipc_bus_s bus;
	assign bus = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

	// highest-priority set bit, lowest index wins
	function automatic logic [3:0] pick(input logic [10:0] req);
		logic [3:0] idx;
		idx = 4'hF;
		for (int i = ipc_pkg::IPC_NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction : pick

	function automatic logic [15:0] vec_of(input logic [3:0] idx);
		logic [15:0] v;
		case (idx)
			4'h0: v = ipc_pkg::IPC_VEC_RESET;
			4'h1: v = ipc_pkg::IPC_VEC_TRAP;
			4'h2: v = ipc_pkg::IPC_VEC_LINE0;
			4'h3: v = ipc_pkg::IPC_VEC_LINE1;
			4'h4: v = ipc_pkg::IPC_VEC_LINE2;
			4'h5: v = ipc_pkg::IPC_VEC_LINE3;
			4'h6: v = ipc_pkg::IPC_VEC_AT_CMP;
			4'h7: v = ipc_pkg::IPC_VEC_AT_OVF;
			4'h8: v = ipc_pkg::IPC_VEC_LT_CAP;
			4'h9: v = ipc_pkg::IPC_VEC_LT_RTB;
			4'hA: v = ipc_pkg::IPC_VEC_SERIAL;
			default: v = ipc_pkg::IPC_VEC_RESET;
		endcase
		return v;
	endfunction : vec_of

	// one decode of the sense code, shared by all four lines
	function automatic logic edge_match(input logic [1:0] fld, input logic rise,
		input logic fall);
		logic hit;
		case (fld)
			ipc_pkg::IPC_SENSE_RISE: hit = rise;
			ipc_pkg::IPC_SENSE_FALL: hit = fall;
			ipc_pkg::IPC_SENSE_BOTH: hit = rise | fall;
			ipc_pkg::IPC_SENSE_FALL_LOW: hit = fall;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : edge_match

	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] sync3_r;
	logic [3:0] line_lvl_r;
	logic [3:0] line_lvl_nxt;

	logic [3:0] blk1_r;
	logic [3:0] blk2_r;
	logic [3:0] blk3_r;
	logic [3:0] blk_n_r;
	logic [3:0] blk_n_nxt;

	logic [7:0] sense_r;
	logic [4:0] enable_r;

	logic [3:0] ext_pend_r;
	logic [3:0] ext_pend_nxt;
	logic [4:0] per_pend_r;
	logic [4:0] per_pend_nxt;

	logic mask_r;
	logic mask_nxt;
	logic boot_r;
	logic trap_pend_r;

	logic [15:0] vector_r;
	logic [3:0] src_r;
	logic [7:0] rdata_r;

	ipc_pkg::ipc_state_e state_r;
	ipc_pkg::ipc_state_e state_nxt;

	// three-stage sync; a change counts only when stages two and three agree
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sync1_r <= 4'hF;
			sync2_r <= 4'hF;
			sync3_r <= 4'hF;
		end else begin
			sync1_r <= EXT_LINE_IN;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// idle lines sit high, so a reset level of ones gives no false edge
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			line_lvl_r <= 4'hF;
		end else begin
			line_lvl_r <= line_lvl_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			blk1_r <= 4'hF;
			blk2_r <= 4'hF;
			blk3_r <= 4'hF;
		end else begin
			blk1_r <= EXT_NAND_BLOCK_N_IN;
			blk2_r <= blk1_r;
			blk3_r <= blk2_r;
		end
	end

	// per-bit agreement, so one noisy pin cannot freeze the others
	assign blk_n_nxt = (~(blk2_r ^ blk3_r) & blk2_r) | ((blk2_r ^ blk3_r) & blk_n_r);

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			blk_n_r <= 4'hF;
		end else begin
			blk_n_r <= blk_n_nxt;
		end
	end

	genvar g;
	wire [3:0] rise_evt;
	wire [3:0] fall_evt;
	wire [3:0] low_lvl;
	wire [3:0] edge_hit;
	generate
		for (g = 0; g < ipc_pkg::IPC_NUM_LINES; g++) begin : g_line
			wire [1:0] fld = sense_r[2*g +: 2];
			assign line_lvl_nxt[g] = (sync2_r[g] == sync3_r[g]) ? sync2_r[g] : line_lvl_r[g];
			assign rise_evt[g] = line_lvl_nxt[g] & ~line_lvl_r[g];
			assign fall_evt[g] = ~line_lvl_nxt[g] & line_lvl_r[g];
			assign low_lvl[g] = (fld == ipc_pkg::IPC_SENSE_FALL_LOW) & ~line_lvl_r[g];
			assign edge_hit[g] = edge_match(fld, rise_evt[g], fall_evt[g]);
		end
	endgenerate

	wire st_run = state_r == ipc_pkg::IPC_ST_RUN;
	wire st_svc = state_r == ipc_pkg::IPC_ST_SVC;
	wire st_wait = state_r == ipc_pkg::IPC_ST_WAIT;
	wire st_halt = state_r == ipc_pkg::IPC_ST_HALT;

	// source vector: 0 reset, 1 trap, 2..5 lines, 6..10 peripherals
	wire [3:0] ext_req = (ext_pend_r | low_lvl) & blk_n_r;
	wire [4:0] per_req = per_pend_r & enable_r;
	wire [10:0] maskable = {per_req, ext_req, 2'b00};
	wire [10:0] unmaskable = {9'h000, trap_pend_r, boot_r};
	wire [10:0] gated = mask_r ? 11'h000 : maskable;
	wire [10:0] serv_req = gated | unmaskable;
	wire [3:0] win = pick(serv_req);
	wire take = (win != 4'hF) & ~st_svc;
	wire run_take = take & (INSTR_END_IN | ~st_run);
	wire [10:0] halt_wake = maskable & ipc_pkg::IPC_HALT_WAKE_MASK;
	wire wake_wait = st_wait & (|maskable);
	wire wake_halt = st_halt & (|halt_wake);
	wire stall_halt = st_halt & ~(|halt_wake);
	wire svc_go = run_take & ~stall_halt;

	// one-hot of the source being entered this cycle
	wire [10:0] entry = svc_go ? 11'(11'h001 << win) : 11'h000;
	wire [3:0] take_line = entry[5:2];

	wire sel_sense = bus.addr == ipc_pkg::IPC_ADDR_SENSE;
	wire sel_enable = bus.addr == ipc_pkg::IPC_ADDR_ENABLE;
	wire sel_pend = bus.addr == ipc_pkg::IPC_ADDR_PEND;
	wire sel_status = bus.addr == ipc_pkg::IPC_ADDR_STATUS;

	// sense writes are dropped, not deferred, while the mask is clear
	wire wr_sense = bus.wr & sel_sense & mask_r;
	wire wr_enable = bus.wr & sel_enable;
	wire wr_pend = bus.wr & sel_pend;
	wire [4:0] sw_clr = (wr_pend ? ~bus.wdata[4:0] : 5'h00) | PERIPH_FLAG_CLR_IN;

	// edge latches clear on entry; a new edge in that cycle still wins
	assign ext_pend_nxt = (ext_pend_r & ~take_line) | edge_hit;
	// peripheral flags are cleared by software only, never by vector fetch
	assign per_pend_nxt = (per_pend_r & ~sw_clr) | PERIPH_FLAG_SET_IN;

	always_comb begin
		state_nxt = state_r;
		mask_nxt = mask_r;
		case (state_r)
			ipc_pkg::IPC_ST_RUN: begin
				// pending service wins over return, wait or halt
				if (svc_go) begin
					state_nxt = ipc_pkg::IPC_ST_SVC;
				end else if (IRQ_RETURN_INSTR_EXEC_IN) begin
					mask_nxt = 1'b0;
				// low-power entry opens the mask so a wake source is served
				end else if (WAIT_EXEC_IN) begin
					state_nxt = ipc_pkg::IPC_ST_WAIT;
					mask_nxt = 1'b0;
				end else if (HALT_EXEC_IN) begin
					state_nxt = ipc_pkg::IPC_ST_HALT;
					mask_nxt = 1'b0;
				end
			end

			ipc_pkg::IPC_ST_SVC: begin
				if (STACK_DONE_IN) begin
					state_nxt = ipc_pkg::IPC_ST_RUN;
					mask_nxt = 1'b1;
				end
			end

			ipc_pkg::IPC_ST_WAIT, ipc_pkg::IPC_ST_HALT: begin
				if (svc_go) begin
					state_nxt = ipc_pkg::IPC_ST_SVC;
				end
			end

			default: begin
				state_nxt = ipc_pkg::IPC_ST_RUN;
			end
		endcase
	end

	// status word: pending lines, spare, state, mask
	wire [7:0] status_word = {ext_pend_r, 1'b0, state_r, mask_r};
	wire [7:0] rd_mux = sel_sense ? sense_r :
		sel_enable ? {3'h0, enable_r} :
		sel_pend ? {3'h0, per_pend_r} :
		sel_status ? status_word : 8'h00;
	// read data returns to zero outside the answer cycle
	wire [7:0] rdata_nxt = bus.rd ? rd_mux : 8'h00;

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sense_r <= ipc_pkg::IPC_SENSE_RESET;
		end else if (wr_sense) begin
			sense_r <= bus.wdata;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			enable_r <= ipc_pkg::IPC_ENABLE_RESET;
		end else if (wr_enable) begin
			enable_r <= bus.wdata[4:0];
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ext_pend_r <= 4'h0;
		end else begin
			ext_pend_r <= ext_pend_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			per_pend_r <= 5'h00;
		end else begin
			per_pend_r <= per_pend_nxt;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			mask_r <= 1'b1;
			state_r <= ipc_pkg::IPC_ST_RUN;
		end else begin
			mask_r <= mask_nxt;
			state_r <= state_nxt;
		end
	end

	// reset source is served once, then not again until the next reset
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			boot_r <= 1'b1;
		end else if (entry[0]) begin
			boot_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			trap_pend_r <= 1'b0;
		end else begin
			trap_pend_r <= (trap_pend_r & ~entry[1]) | TRAP_EXEC_IN;
		end
	end

	// vector and source id hold through the whole context push
	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			vector_r <= 16'h0000;
		end else if (svc_go) begin
			vector_r <= vec_of(win);
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			src_r <= 4'h0;
		end else if (svc_go) begin
			src_r <= win;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA_OUT = rdata_r;
	assign GLOBAL_MASK_OUT = mask_r;
	assign SVC_REQ_OUT = st_svc;
	assign STACK_PUSH_OUT = st_svc & (src_r != 4'h0);
	assign STACK_POP_OUT = IRQ_RETURN_INSTR_EXEC_IN & st_run & ~svc_go;
	assign VECTOR_OUT = vector_r;
	assign SRC_ID_OUT = src_r;
	assign WAIT_STATE_OUT = st_wait;
	assign HALT_STATE_OUT = st_halt;
	assign WAKE_OUT = wake_wait | wake_halt;
endmodule : ipc_interrupt_priority_controller
`default_nettype wire

/* File: ipc_interrupt_priority_controller_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ipc_checker (
	input wire logic SYS_CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic REG_RD_IN,
	input wire logic [3:0] REG_ADDR_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic IRQ_RETURN_INSTR_EXEC_IN,
	input wire logic STACK_DONE_IN,
	input wire logic GLOBAL_MASK_OUT,
	input wire logic SVC_REQ_OUT,
	input wire logic STACK_PUSH_OUT,
	input wire logic STACK_POP_OUT,
	input wire logic [15:0] VECTOR_OUT,
	input wire logic WAIT_STATE_OUT,
	input wire logic HALT_STATE_OUT,
	input wire logic WAKE_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	wire logic run_w = !SVC_REQ_OUT && !WAIT_STATE_OUT && !HALT_STATE_OUT;
	a_reset_mask: assert property (!$past(RESET_N_IN) |-> GLOBAL_MASK_OUT)
		else $error("mask clear after reset");
	a_masked_only_trap: assert property ($rose(SVC_REQ_OUT) && $past(GLOBAL_MASK_OUT)
		|-> VECTOR_OUT inside {16'hFFFE, 16'hFFFC}) else $error("masked source served");
	a_svc_hold: assert property (SVC_REQ_OUT && !STACK_DONE_IN
		|=> SVC_REQ_OUT && $stable(VECTOR_OUT)) else $error("service dropped early");
	a_done_mask: assert property (SVC_REQ_OUT && STACK_DONE_IN
		|=> GLOBAL_MASK_OUT && !SVC_REQ_OUT) else $error("mask not set on entry");
	a_push_svc: assert property (SVC_REQ_OUT && VECTOR_OUT != 16'hFFFE |-> STACK_PUSH_OUT)
		else $error("no context push");
	a_irq_return_instr_unmask: assert property (run_w && IRQ_RETURN_INSTR_EXEC_IN |-> STACK_POP_OUT ##1 !GLOBAL_MASK_OUT)
		else $error("return left mask set");
	a_halt_wake: assert property ($rose(SVC_REQ_OUT) && $past(HALT_STATE_OUT)
		|-> !(VECTOR_OUT inside {16'hFFFC, 16'hFFEA, 16'hFFE6})) else $error("bad halt exit");
	a_wait_wake: assert property (WAIT_STATE_OUT && WAKE_OUT |=> SVC_REQ_OUT)
		else $error("no wake from wait");
	a_status_mask: assert property (REG_RD_IN && REG_ADDR_IN == 4'h3
		|=> REG_RDATA_OUT[0] == $past(GLOBAL_MASK_OUT)) else $error("status mask bit");
	cover property ($rose(SVC_REQ_OUT) && VECTOR_OUT == 16'hFFE2);
	cover property (HALT_STATE_OUT && WAKE_OUT);
	cover property (WAIT_STATE_OUT ##1 SVC_REQ_OUT);
endmodule : ipc_checker
bind ipc_interrupt_priority_controller ipc_checker u_chk (.SYS_CLK_IN, .RESET_N_IN, .REG_RD_IN,
	.REG_ADDR_IN, .REG_RDATA_OUT, .IRQ_RETURN_INSTR_EXEC_IN, .STACK_DONE_IN, .GLOBAL_MASK_OUT, .SVC_REQ_OUT,
	.STACK_PUSH_OUT, .STACK_POP_OUT, .VECTOR_OUT, .WAIT_STATE_OUT, .HALT_STATE_OUT, .WAKE_OUT);
`default_nettype wire

/* File: ipc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ipc_core_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic svc_in,
	input wire logic slow_in,
	output logic instr_end_out,
	output logic stack_done_out
);
	logic [2:0] cnt_r;
	logic [1:0] ph_r;
	// boundary every fourth cycle, none while the context is pushed
	assign instr_end_out = ph_r == 2'h3 && !svc_in;
	assign stack_done_out = svc_in && cnt_r == (slow_in ? 3'h4 : 3'h1);
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r <= 3'h0;
			ph_r <= 2'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
			cnt_r <= svc_in ? cnt_r + 3'h1 : 3'h0;
		end
	end
endmodule : ipc_core_model
`default_nettype wire

/* File: ipc_interrupt_priority_controller_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module ipc_interrupt_priority_controller_bench;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, slow = 0, rd_q = 0, svc_q = 0;
	logic ie, sd, svc, msk;
	logic [3:0] addr = 4'h0, ext = 4'hF, ctl = 4'h0, nblk = 4'hF;
	logic [7:0] wd = 8'h00, rdat;
	logic [4:0] pset = 5'h00, pclr = 5'h00;
	logic [15:0] vec;
	logic [31:0] seed = 32'h4450CE48;
	int failures = 0, check_count = 0, cyc = 0;
	logic [7:0] rq[$];
	logic [15:0] vq[$];
	always #25 clk = ~clk;
	ipc_interrupt_priority_controller u_dut (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdat), .EXT_LINE_IN(ext), .EXT_NAND_BLOCK_N_IN(nblk),
		.PERIPH_FLAG_SET_IN(pset), .PERIPH_FLAG_CLR_IN(pclr), .INSTR_END_IN(ie),
		.TRAP_EXEC_IN(ctl[0]), .IRQ_RETURN_INSTR_EXEC_IN(ctl[1]), .WAIT_EXEC_IN(ctl[2]),
		.HALT_EXEC_IN(ctl[3]), .STACK_DONE_IN(sd), .GLOBAL_MASK_OUT(msk), .SVC_REQ_OUT(svc),
		.STACK_PUSH_OUT(), .STACK_POP_OUT(), .VECTOR_OUT(vec), .SRC_ID_OUT(),
		.WAIT_STATE_OUT(), .HALT_STATE_OUT(), .WAKE_OUT());
	ipc_core_model u_core (.clk_in(clk), .rst_n_in(rst_n), .svc_in(svc), .slow_in(slow),
		.instr_end_out(ie), .stack_done_out(sd));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t read %h exp %h", $time, g, e);
		end
	endtask : cmp8
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("mismatch %0t vector %h exp %h", $time, g, e);
		end
	endtask : cmp16
	task automatic summarize();
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		rq.push_back(e);
		@(posedge clk);
		rd <= 0;
	endtask : rreg
	task automatic pulse(input logic [3:0] c, input logic [4:0] s, input logic [4:0] k);
		@(posedge clk);
		ctl <= c;
		pset <= s;
		pclr <= k;
		@(posedge clk);
		ctl <= 4'h0;
		pset <= 5'h00;
		pclr <= 5'h00;
	endtask : pulse
	// slow or prompt context push, then optional return
	task automatic serve(input logic ret, input logic [4:0] clr);
		int n = 0;
		seed = lfsr(seed);
		slow <= seed[0];
		while (!svc && n < 300) begin
			@(negedge clk);
			n++;
		end
		while (svc && n < 600) begin
			@(negedge clk);
			n++;
		end
		if (ret)
			pulse(4'h2, 5'h00, clr);
	endtask : serve
	// outputs are looked at mid-cycle, where they are settled
	always @(negedge clk) begin
		cyc++;
		rd_q <= rd;
		svc_q <= svc;
		if (rd_q)
			cmp8(rdat, rq.pop_front());
		if (svc && !svc_q)
			cmp16(vec, vq.size() > 0 ? vq.pop_front() : 16'h0000);
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end
	initial begin
		vq.push_back(ipc_pkg::IPC_VEC_RESET);
		repeat (16) @(posedge clk);
		rst_n <= 1;
		rreg(4'h3, 8'h01);
		serve(0, 5'h00);
		wreg(4'h0, 8'hE4);
		wreg(4'h1, 8'h1F);
		rreg(4'h0, 8'hE4);
		pulse(4'h2, 5'h00, 5'h00);
		seed = lfsr(seed);
		wreg(4'h0, seed[7:0]);
		wreg(4'h3, seed[15:8]);
		rreg(4'h0, 8'hE4);
		rreg(4'h5, 8'h00);
		rreg(4'h3, 8'h00);
		vq.push_back(ipc_pkg::IPC_VEC_TRAP);
		pulse(4'h1, 5'h00, 5'h00);
		serve(0, 5'h00);
		ext <= 4'h0;
		pulse(4'h0, 5'h1F, 5'h00);
		repeat (5) @(posedge clk);
		ext <= 4'hF;
		pulse(4'h0, 5'h00, 5'h04);
		rreg(4'h2, 8'h1B);
		pulse(4'h0, 5'h04, 5'h00);
		repeat (8) @(posedge clk);
		// every code of the sense field is in play here
		for (int i = 0; i < 9; i++)
			vq.push_back(16'(i < 4 ? 32'hFFF8 - 2 * i : 32'hFFEA - 2 * (i - 4)));
		pulse(4'h2, 5'h00, 5'h00);
		for (int i = 0; i < 9; i++)
			serve(1, 5'(i < 4 ? 0 : 1 << (i - 4)));
		pulse(4'h4, 5'h00, 5'h00);
		rreg(4'h3, 8'h06);
		vq.push_back(ipc_pkg::IPC_VEC_LT_CAP);
		pulse(4'h0, 5'h04, 5'h00);
		serve(1, 5'h04);
		pulse(4'h8, 5'h01, 5'h00);
		repeat (6) @(posedge clk);
		rreg(4'h3, 8'h04);
		pulse(4'h0, 5'h00, 5'h01);
		vq.push_back(ipc_pkg::IPC_VEC_LT_RTB);
		pulse(4'h0, 5'h08, 5'h00);
		serve(1, 5'h08);
		// a low contributing pin holds latched line requests back
		nblk <= 4'h0;
		repeat (4) @(posedge clk);
		ext <= 4'h0;
		repeat (6) @(posedge clk);
		ext <= 4'hF;
		repeat (6) @(posedge clk);
		rreg(4'h3, 8'hF0);
		for (int i = 0; i < 4; i++)
			vq.push_back(16'(32'hFFF8 - 2 * i));
		nblk <= 4'hF;
		repeat (4) serve(1, 5'h00);
		repeat (4) @(posedge clk);
		cmp16(16'(vq.size()), 16'h0000);
		summarize();
	end
endmodule : ipc_interrupt_priority_controller_bench
`default_nettype wire
